// File: src/clock_ctrl_pkg.sv
// Functional notes
// - Main clock: any oscillator but module oscillator, divide 1-128
// - Main clock drives CPU, memories, CRC, ports
// - Sub-main clock is main divided 1, 2, 4, 8
// - Aux clock from crystal or internal RC oscillator
// - Digital oscillator lockable to either reference
// - Crystal failure handled by fail-safe substitution
// - Timer select: 00 pin, 01 aux, 10 sub-main
// - Serial select: 00 pin, 01 aux, 1x sub-main
// - Converter select: 00 module, 01 aux, 1x sub-main
// - RTC select: 11 ULP, 10 crystal, 01 bit-chosen
// - Crystal selected by codes 10b, 0b, 0b, 10b
package clock_ctrl_pkg;

   // Clock rate and fail-safe timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned XTAL_TIMEOUT_US = 125; // Crystal silence limit
   localparam int unsigned XTAL_TIMEOUT_CYC = (XTAL_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register byte addresses
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] CLK_CTRL_ADDR = 8'h00;
   localparam logic [7:0] PERIPH_SEL_ADDR = 8'h04;
   localparam logic [7:0] FLL_TARGET_ADDR = 8'h08;
   localparam logic [7:0] STATUS_ADDR = 8'h0c;

   // Clock control register fields
   localparam int unsigned MAIN_SRC_LSB = 0; // 2 bits
   localparam int unsigned MAIN_DIV_LSB = 2; // 3 bits, divide by 2**code
   localparam int unsigned SUB_DIV_LSB = 5; // 2 bits, divide by 2**code
   localparam int unsigned AUX_SRC_BIT = 7;
   localparam int unsigned LOCK_REF_BIT = 8;
   localparam int unsigned FLL_EN_BIT = 9;
   localparam int unsigned FAILSAFE_EN_BIT = 10;
   localparam logic [31:0] CLK_CTRL_MASK = 32'h0000_07ff;
   localparam logic [31:0] CLK_CTRL_RST = 32'h0000_0400;

   // Peripheral select register fields
   localparam int unsigned TIMER_SEL_LSB = 0;
   localparam int unsigned SERIAL_SEL_LSB = 2;
   localparam int unsigned WDOG_SEL_LSB = 4;
   localparam int unsigned CONV_SEL_LSB = 6;
   localparam int unsigned RTC_SEL_LSB = 8;
   localparam int unsigned RTC_CHOICE_BIT = 10;
   localparam logic [31:0] PERIPH_SEL_MASK = 32'h0000_07ff;
   localparam logic [31:0] PERIPH_SEL_RST = 32'h0000_000a;

   // Lock target register
   localparam int unsigned FLL_CNT_W = 10;
   localparam logic [31:0] FLL_TARGET_MASK = 32'h0000_03ff;
   localparam logic [31:0] FLL_TARGET_RST = 32'h0000_0100;

   // Status register fields
   localparam int unsigned FAULT_BIT = 0;
   localparam int unsigned ABSENT_BIT = 1;
   localparam int unsigned TRIM_UP_BIT = 2;
   localparam int unsigned TRIM_DOWN_BIT = 3;
   localparam int unsigned MEASURED_LSB = 16;

   // Source select codes
   localparam logic [1:0] MAIN_DIG = 2'h0;
   localparam logic [1:0] MAIN_RC = 2'h1;
   localparam logic [1:0] MAIN_XTAL = 2'h2;
   localparam logic [1:0] MAIN_ULP = 2'h3;
   localparam logic [1:0] SEL_00 = 2'h0;
   localparam logic [1:0] SEL_01 = 2'h1;
   localparam logic [1:0] SEL_10 = 2'h2;
   localparam logic [1:0] SEL_11 = 2'h3;

   // Index of each sampled source
   localparam int unsigned SRC_XTAL = 0;
   localparam int unsigned SRC_RC = 1;
   localparam int unsigned SRC_ULP = 2;
   localparam int unsigned SRC_DIG = 3;
   localparam int unsigned SRC_MOD = 4;
   localparam int unsigned SRC_TPIN = 5;
   localparam int unsigned SRC_SPIN = 6;
   localparam int unsigned NUM_SRC = 7;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: src/clock_edge_sync.sv
`timescale 1ns/1ps
// Synchronises one oscillator or pin and marks its rising edges
module clock_edge_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic async_in,
   output logic rise_pulse
);
   logic meta_reg; // First stage, read only by the second
   logic sync_reg; // Second stage, safe to use
   logic prev_reg; // Delayed copy for edge detection
   logic rise_reg;
   logic rise_next;

   // Low-to-high step of the synchronised level
   always_comb
   begin
      rise_next = sync_reg & ~prev_reg;
   end

   // Synchroniser and edge register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
         rise_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
         rise_reg <= rise_next;
      end
   end

   assign rise_pulse = rise_reg;
endmodule

// File: src/clock_source_distribution.sv
`timescale 1ns/1ps
// Clock selection and division as one-cycle enables on aclk
module clock_source_distribution #(
   parameter int unsigned XTAL_TIMEOUT = clock_ctrl_pkg::XTAL_TIMEOUT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [clock_ctrl_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [clock_ctrl_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Oscillators and external clock pins, all asynchronous
   input wire logic crystal_low_freq_clock,
   input wire logic internal_rc_32k_oscillator,
   input wire logic very_low_power_osc_clock,
   input wire logic digitally_controlled_oscillator,
   input wire logic module_oscillator_clock,
   input wire logic timer_external_clock_pin,
   input wire logic serial_external_clock_pin,
   // Clock enables toward the clocked logic
   output logic main_clock_en,
   output logic submain_peripheral_clock_en,
   output logic aux_clock_en,
   output logic timer_clock_en,
   output logic serial_clock_en,
   output logic watchdog_clock_en,
   output logic converter_clock_en,
   output logic rtc_clock_en,
   // Status outputs
   output logic crystal_fault,
   output logic osc_trim_up,
   output logic osc_trim_down
);
   import clock_ctrl_pkg::*;

   localparam int unsigned XT_W = $clog2(XTAL_TIMEOUT + 1);

   logic [NUM_SRC-1:0] async_src; // Raw source levels
   logic [NUM_SRC-1:0] edge_pulse; // One pulse per source rising edge

   // Bus state
   logic aw_held_reg, aw_held_next;
   logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic w_held_reg, w_held_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;

   // Software-visible configuration
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] psel_reg, psel_next;
   logic [31:0] target_reg, target_next;
   logic fault_clear; // Write of one to the fault bit

   // Clock generation state
   logic [XT_W-1:0] xt_cnt_reg, xt_cnt_next;
   logic fault_reg, fault_next;
   logic [4:0] main_cfg_reg, main_cfg_next; // Applied source and divider
   logic [6:0] main_cnt_reg, main_cnt_next;
   logic [1:0] sub_cfg_reg, sub_cfg_next;
   logic [2:0] sub_cnt_reg, sub_cnt_next;
   logic [FLL_CNT_W-1:0] fll_cnt_reg, fll_cnt_next;
   logic [FLL_CNT_W-1:0] measured_reg, measured_next;
   logic up_reg, up_next;
   logic down_reg, down_next;
   logic main_reg, main_next;
   logic sub_reg, sub_next;
   logic aux_reg, aux_next;
   logic timer_reg, timer_next;
   logic serial_reg, serial_next;
   logic wdog_reg, wdog_next;
   logic conv_reg, conv_next;
   logic rtc_reg, rtc_next;

   // Byte-lane write merge, reserved bits forced low
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[b*8 +: 8] = val[b*8 +: 8];
         end
      end
      return res & mask;
   endfunction

   // Terminal count of a power-of-two divider
   function automatic logic [6:0] div_limit(input logic [2:0] code);
      logic [7:0] full;
      full = (8'h01 << code) - 8'h01;
      return full[6:0];
   endfunction

   assign async_src[SRC_XTAL] = crystal_low_freq_clock;
   assign async_src[SRC_RC] = internal_rc_32k_oscillator;
   assign async_src[SRC_ULP] = very_low_power_osc_clock;
   assign async_src[SRC_DIG] = digitally_controlled_oscillator;
   assign async_src[SRC_MOD] = module_oscillator_clock;
   assign async_src[SRC_TPIN] = timer_external_clock_pin;
   assign async_src[SRC_SPIN] = serial_external_clock_pin;

   // Two flops on every source before any logic
   for (genvar i = 0; i < NUM_SRC; i++)
   begin : g_sync
      clock_edge_sync u_sync (
         .aclk(aclk),
         .aresetn(aresetn),
         .async_in(async_src[i]),
         .rise_pulse(edge_pulse[i])
      );
   end

   // Bus slave: address and data in either order
   always_comb
   begin
      logic aw_have;
      logic w_have;
      logic [ADDR_W-1:0] wa;
      logic [31:0] wd;
      logic [3:0] ws;
      aw_have = aw_held_reg | (awvalid & awready_reg);
      w_have = w_held_reg | (wvalid & wready_reg);
      wa = aw_held_reg ? aw_addr_reg : awaddr;
      wd = w_held_reg ? w_data_reg : wdata;
      ws = w_held_reg ? w_strb_reg : wstrb;
      aw_held_next = aw_have;
      aw_addr_next = wa;
      w_held_next = w_have;
      w_data_next = wd;
      w_strb_next = ws;
      bvalid_next = bvalid_reg & ~bready;
      bresp_next = bresp_reg;
      ctrl_next = ctrl_reg;
      psel_next = psel_reg;
      target_next = target_reg;
      fault_clear = 1'b0;
      if (aw_have && w_have)
      begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = RESP_OKAY;
         if (wa == CLK_CTRL_ADDR)
         begin
            ctrl_next = merge(ctrl_reg, wd, ws, CLK_CTRL_MASK);
         end
         else if (wa == PERIPH_SEL_ADDR)
         begin
            psel_next = merge(psel_reg, wd, ws, PERIPH_SEL_MASK);
         end
         else if (wa == FLL_TARGET_ADDR)
         begin
            target_next = merge(target_reg, wd, ws, FLL_TARGET_MASK);
         end
         else if (wa == STATUS_ADDR)
         begin
            fault_clear = ws[0] & wd[FAULT_BIT]; // Other status bits are read-only
         end
         else
         begin
            bresp_next = RESP_SLVERR; // Unmapped address
         end
      end
      awready_next = ~aw_held_next & ~bvalid_next;
      wready_next = ~w_held_next & ~bvalid_next;
      // Read channel
      rvalid_next = rvalid_reg & ~rready;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (arvalid && arready_reg)
      begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         rdata_next = '0;
         if (araddr == CLK_CTRL_ADDR)
         begin
            rdata_next = ctrl_reg;
         end
         else if (araddr == PERIPH_SEL_ADDR)
         begin
            rdata_next = psel_reg;
         end
         else if (araddr == FLL_TARGET_ADDR)
         begin
            rdata_next = target_reg;
         end
         else if (araddr == STATUS_ADDR)
         begin
            rdata_next[FAULT_BIT] = fault_reg;
            rdata_next[ABSENT_BIT] = (xt_cnt_reg == XT_W'(XTAL_TIMEOUT));
            rdata_next[TRIM_UP_BIT] = up_reg;
            rdata_next[TRIM_DOWN_BIT] = down_reg;
            rdata_next[MEASURED_LSB +: FLL_CNT_W] = measured_reg;
         end
         else
         begin
            rresp_next = RESP_SLVERR;
         end
      end
      arready_next = ~rvalid_next;
   end

   // Clock selection, division and distribution
   always_comb
   begin
      logic xt_absent;
      logic xtal_eff;
      logic main_src_pulse;
      logic ref_pulse;
      logic [4:0] main_want;
      logic [1:0] sub_want;
      logic [1:0] code;
      main_src_pulse = 1'b0;
      // Fail-safe: a silent crystal is replaced by the RC oscillator
      xt_absent = (xt_cnt_reg == XT_W'(XTAL_TIMEOUT));
      xt_cnt_next = edge_pulse[SRC_XTAL] ? '0 : (xt_absent ? xt_cnt_reg : xt_cnt_reg + 1'b1);
      xtal_eff = (ctrl_reg[FAILSAFE_EN_BIT] && xt_absent) ? edge_pulse[SRC_RC] : edge_pulse[SRC_XTAL];
      // Fault set wins over a same-cycle clear
      fault_next = xt_absent ? 1'b1 : (fault_clear ? 1'b0 : fault_reg);
      // Main clock source; module oscillator cannot be chosen
      case (main_cfg_reg[1:0])
         MAIN_DIG: main_src_pulse = edge_pulse[SRC_DIG];
         MAIN_RC: main_src_pulse = edge_pulse[SRC_RC];
         MAIN_XTAL: main_src_pulse = xtal_eff;
         default: main_src_pulse = edge_pulse[SRC_ULP];
      endcase
      // Divider restarts on any setting change so the first period is whole
      main_want = {ctrl_reg[MAIN_DIV_LSB +: 3], ctrl_reg[MAIN_SRC_LSB +: 2]};
      main_cfg_next = main_want;
      main_cnt_next = main_cnt_reg;
      main_next = 1'b0;
      if (main_want != main_cfg_reg)
      begin
         main_cnt_next = 7'h00;
      end
      else if (main_src_pulse)
      begin
         if (main_cnt_reg >= div_limit(main_cfg_reg[4:2]))
         begin
            main_cnt_next = 7'h00;
            main_next = 1'b1;
         end
         else
         begin
            main_cnt_next = main_cnt_reg + 7'h01;
         end
      end
      // Sub-main counts main pulses, so it can never be faster
      sub_want = ctrl_reg[SUB_DIV_LSB +: 2];
      sub_cfg_next = sub_want;
      sub_cnt_next = sub_cnt_reg;
      sub_next = 1'b0;
      if (sub_want != sub_cfg_reg)
      begin
         sub_cnt_next = 3'h0;
      end
      else if (main_next)
      begin
         if ({4'h0, sub_cnt_reg} >= div_limit({1'b0, sub_cfg_reg}))
         begin
            sub_cnt_next = 3'h0;
            sub_next = 1'b1;
         end
         else
         begin
            sub_cnt_next = sub_cnt_reg + 3'h1;
         end
      end
      // Aux from the two low-frequency sources
      aux_next = ctrl_reg[AUX_SRC_BIT] ? edge_pulse[SRC_RC] : xtal_eff;
      // Timer, reserved code stops the clock
      code = psel_reg[TIMER_SEL_LSB +: 2];
      case (code)
         SEL_00: timer_next = edge_pulse[SRC_TPIN];
         SEL_01: timer_next = aux_next;
         SEL_10: timer_next = sub_next;
         default: timer_next = 1'b0;
      endcase
      code = psel_reg[SERIAL_SEL_LSB +: 2];
      case (code)
         SEL_00: serial_next = edge_pulse[SRC_SPIN];
         SEL_01: serial_next = aux_next;
         default: serial_next = sub_next;
      endcase
      code = psel_reg[WDOG_SEL_LSB +: 2];
      case (code)
         SEL_00: wdog_next = sub_next;
         SEL_01: wdog_next = aux_next;
         SEL_10: wdog_next = edge_pulse[SRC_ULP];
         default: wdog_next = 1'b0;
      endcase
      code = psel_reg[CONV_SEL_LSB +: 2];
      case (code)
         SEL_00: conv_next = edge_pulse[SRC_MOD];
         SEL_01: conv_next = aux_next;
         default: conv_next = sub_next;
      endcase
      code = psel_reg[RTC_SEL_LSB +: 2];
      case (code)
         SEL_01: rtc_next = psel_reg[RTC_CHOICE_BIT] ? aux_next : sub_next;
         SEL_10: rtc_next = xtal_eff;
         SEL_11: rtc_next = edge_pulse[SRC_ULP];
         default: rtc_next = 1'b0;
      endcase
      // Frequency lock: count oscillator edges over one reference period
      ref_pulse = ctrl_reg[LOCK_REF_BIT] ? edge_pulse[SRC_RC] : xtal_eff;
      fll_cnt_next = fll_cnt_reg;
      measured_next = measured_reg;
      up_next = up_reg;
      down_next = down_reg;
      if (!ctrl_reg[FLL_EN_BIT])
      begin
         fll_cnt_next = '0;
         up_next = 1'b0;
         down_next = 1'b0;
      end
      else if (ref_pulse)
      begin
         measured_next = fll_cnt_reg;
         fll_cnt_next = {{(FLL_CNT_W-1){1'b0}}, edge_pulse[SRC_DIG]};
         up_next = (fll_cnt_reg < target_reg[FLL_CNT_W-1:0]);
         down_next = (fll_cnt_reg > target_reg[FLL_CNT_W-1:0]);
      end
      else if (edge_pulse[SRC_DIG] && (fll_cnt_reg != '1))
      begin
         fll_cnt_next = fll_cnt_reg + 1'b1; // Saturates so a stopped reference cannot wrap
      end
   end

   // State registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
         ctrl_reg <= CLK_CTRL_RST;
         psel_reg <= PERIPH_SEL_RST;
         target_reg <= FLL_TARGET_RST;
         xt_cnt_reg <= '0;
         fault_reg <= 1'b0;
         main_cfg_reg <= 5'h00;
         main_cnt_reg <= 7'h00;
         sub_cfg_reg <= 2'h0;
         sub_cnt_reg <= 3'h0;
         fll_cnt_reg <= '0;
         measured_reg <= '0;
         up_reg <= 1'b0;
         down_reg <= 1'b0;
         main_reg <= 1'b0;
         sub_reg <= 1'b0;
         aux_reg <= 1'b0;
         timer_reg <= 1'b0;
         serial_reg <= 1'b0;
         wdog_reg <= 1'b0;
         conv_reg <= 1'b0;
         rtc_reg <= 1'b0;
      end
      else
      begin
         aw_held_reg <= aw_held_next;
         aw_addr_reg <= aw_addr_next;
         w_held_reg <= w_held_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         ctrl_reg <= ctrl_next;
         psel_reg <= psel_next;
         target_reg <= target_next;
         xt_cnt_reg <= xt_cnt_next;
         fault_reg <= fault_next;
         main_cfg_reg <= main_cfg_next;
         main_cnt_reg <= main_cnt_next;
         sub_cfg_reg <= sub_cfg_next;
         sub_cnt_reg <= sub_cnt_next;
         fll_cnt_reg <= fll_cnt_next;
         measured_reg <= measured_next;
         up_reg <= up_next;
         down_reg <= down_next;
         main_reg <= main_next;
         sub_reg <= sub_next;
         aux_reg <= aux_next;
         timer_reg <= timer_next;
         serial_reg <= serial_next;
         wdog_reg <= wdog_next;
         conv_reg <= conv_next;
         rtc_reg <= rtc_next;
      end
   end

   // Outputs straight from flops; one-cycle enables cannot form runts
   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign main_clock_en = main_reg;
   assign submain_peripheral_clock_en = sub_reg;
   assign aux_clock_en = aux_reg;
   assign timer_clock_en = timer_reg;
   assign serial_clock_en = serial_reg;
   assign watchdog_clock_en = wdog_reg;
   assign converter_clock_en = conv_reg;
   assign rtc_clock_en = rtc_reg;
   assign crystal_fault = fault_reg;
   assign osc_trim_up = up_reg;
   assign osc_trim_down = down_reg;
endmodule

// File: tb/clock_dist_props.sv
`timescale 1ns/1ps
// Port-level checks of enable pulses, fail-safe flag and bus handshakes
module clock_dist_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic main_clock_en,
   input wire logic submain_peripheral_clock_en,
   input wire logic aux_clock_en,
   input wire logic timer_clock_en,
   input wire logic crystal_fault,
   input wire logic osc_trim_up,
   input wire logic osc_trim_down
);
   // One clock domain
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   main_pulse_a: assert property (main_clock_en |=> !main_clock_en)
      else $error("main enable wider than one cycle");
   sub_in_main_a: assert property (submain_peripheral_clock_en |-> main_clock_en)
      else $error("sub-main pulse without main pulse");
   aux_pulse_a: assert property (aux_clock_en |=> !aux_clock_en)
      else $error("aux enable wider than one cycle");
   timer_pulse_a: assert property ($rose(timer_clock_en) |=> $fell(timer_clock_en))
      else $error("timer enable wider than one cycle");
   trim_excl_a: assert property (!(osc_trim_up && osc_trim_down))
      else $error("trim up and down together");
   fault_clear_a: assert property ($fell(crystal_fault) |-> $rose(bvalid))
      else $error("fault flag dropped without a write");
   write_busy_a: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");
   read_busy_a: assert property (rvalid |-> !arready)
      else $error("read accepted while data pending");
   resp_once_a: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");

   // Main scenarios reached
   cover property (crystal_fault);
   cover property (osc_trim_down);
   cover property (submain_peripheral_clock_en);
endmodule

bind clock_source_distribution clock_dist_props u_props (.*);

// File: tb/osc_bank.sv
`timescale 1ns/1ps
// Free-running oscillators and clock pins; the crystal can be stopped
module osc_bank (
   input wire logic xtal_run,
   output logic [6:0] osc
);
   // Half periods in ns, package source order
   localparam int HALF[7] = '{150, 185, 265, 40, 55, 115, 205};
   for (genvar i = 0; i < 7; i++)
   begin : g_osc
      logic q = 1'b0;
      // A stopped crystal holds its level
      always #(HALF[i]) q = (i != 0 || xtal_run) ? ~q : q;
      assign osc[i] = q;
   end
endmodule

// File: tb/tb_clock_source_distribution.sv
`timescale 1ns/1ps
// Register-driven checks of clock selection, division and fail-safe
module tb_clock_source_distribution;
   import clock_ctrl_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic xtal_run; // Crystal stops when low
   logic [6:0] osc; // Sources in package order
   logic [7:0] en; // Main, sub, aux, timer, serial, wdog, conv, rtc
   logic [2:0] st; // Fault, trim up, trim down
   int err_total;
   int checked;
   integer cnt[15]; // Enables 0-7, then source edges 8-14
   int msrc[4] = '{11, 9, 8, 10}; // Edge counter per main code
   int ptab[5][4] = '{'{13, 2, 1, -1}, '{14, 2, 1, 1}, '{1, 2, 10, -1}, '{12, 2, 1, 1}, '{-1, 1, 8, 10}};
   logic [31:0] rst_tab[3] = '{CLK_CTRL_RST, PERIPH_SEL_RST, FLL_TARGET_RST};

   osc_bank u_osc (.xtal_run(xtal_run), .osc(osc));
   // Short timeout keeps the dead-crystal wait brief
   clock_source_distribution #(.XTAL_TIMEOUT(200)) u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .crystal_low_freq_clock(osc[0]),
      .internal_rc_32k_oscillator(osc[1]), .very_low_power_osc_clock(osc[2]),
      .digitally_controlled_oscillator(osc[3]), .module_oscillator_clock(osc[4]),
      .timer_external_clock_pin(osc[5]), .serial_external_clock_pin(osc[6]), .main_clock_en(en[0]),
      .submain_peripheral_clock_en(en[1]), .aux_clock_en(en[2]), .timer_clock_en(en[3]),
      .serial_clock_en(en[4]), .watchdog_clock_en(en[5]), .converter_clock_en(en[6]), .rtc_clock_en(en[7]),
      .crystal_fault(st[0]), .osc_trim_up(st[1]), .osc_trim_down(st[2]));

   task automatic report_and_stop();
      if (err_total == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One pulse of slack at window edges; zero is exact
   task automatic near(input integer got, input integer exp);
      check((exp != 0 && got - exp <= 1 && exp - got <= 1) ? exp : got, exp);
   endtask

   // Wait bound used up: mismatch, then stop
   task automatic timeout(input int n);
      if (n >= 60)
      begin
         err_total++;
         report_and_stop();
      end
   endtask

   // Address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid && n < 60);
      timeout(n);
      check(bresp, er);
   endtask

   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid && n < 60);
      timeout(n);
      d = rdata;
      r = rresp;
   endtask

   // Enable pulses and source edges over one window
   task automatic measure();
      logic [6:0] prev;
      repeat (10) @(posedge aclk);
      cnt = '{default: 0};
      prev = osc;
      repeat (2000)
      begin
         @(posedge aclk);
         for (int i = 0; i < 8; i++) cnt[i] += en[i];
         for (int i = 0; i < 7; i++) cnt[8 + i] += osc[i] & ~prev[i];
         prev = osc;
      end
   endtask

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      xtal_run = 1'b1;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (rst_tab[i])
      begin
         rdr(8'(i * 4), rd, rs);
         check(rd, rst_tab[i]);
      end
      wr(8'h10, 32'h1, RESP_SLVERR);
      rdr(8'h10, rd, rs);
      check(rs, RESP_SLVERR);
      check(rd, 32'h0);
      wr(CLK_CTRL_ADDR, 32'hffff_fc00, RESP_OKAY);
      rdr(CLK_CTRL_ADDR, rd, rs);
      check(rd, 32'h400);
      // Every main source at divide by one, crystal and RC aux
      foreach (msrc[c])
      begin
         wr(CLK_CTRL_ADDR, 32'h400 | c, RESP_OKAY);
         measure();
         near(cnt[0], cnt[msrc[c]]);
         near(cnt[2], cnt[8]);
      end
      wr(CLK_CTRL_ADDR, 32'h480, RESP_OKAY);
      measure();
      near(cnt[2], cnt[9]);
      // All main and sub-main divide codes
      for (int d = 0; d < 8; d++)
      begin
         wr(CLK_CTRL_ADDR, 32'h400 | (d << 2) | ((d & 3) << 5), RESP_OKAY);
         measure();
         near(cnt[0], cnt[11] >> d);
         near(cnt[1], cnt[0] >> (d & 3));
      end
      wr(CLK_CTRL_ADDR, 32'h400, RESP_OKAY);
      // Every peripheral select code
      for (int p = 0; p < 5; p++)
         for (int c = 0; c < 4; c++)
         begin
            wr(PERIPH_SEL_ADDR, c << (2 * p), RESP_OKAY);
            measure();
            near(cnt[3 + p], ptab[p][c] < 0 ? 0 : cnt[ptab[p][c]]);
         end
      wr(PERIPH_SEL_ADDR, 32'h500, RESP_OKAY);
      measure();
      near(cnt[7], cnt[2]);
      // Lock loop against crystal then RC reference
      wr(FLL_TARGET_ADDR, 32'h1, RESP_OKAY);
      wr(CLK_CTRL_ADDR, 32'h600, RESP_OKAY);
      repeat (200) @(posedge aclk);
      check(st[2:1], 2'b10);
      wr(FLL_TARGET_ADDR, 32'h100, RESP_OKAY);
      wr(CLK_CTRL_ADDR, 32'h700, RESP_OKAY);
      repeat (200) @(posedge aclk);
      check(st[2:1], 2'b01);
      // Dead crystal: aux on RC, fault sticky until cleared
      xtal_run <= 1'b0;
      repeat (400) @(posedge aclk);
      rdr(STATUS_ADDR, rd, rs);
      check({st[0], rd[1:0]}, 3'b111);
      measure();
      near(cnt[2], cnt[9]);
      xtal_run <= 1'b1;
      repeat (100) @(posedge aclk);
      wr(STATUS_ADDR, 32'h1, RESP_OKAY);
      rdr(STATUS_ADDR, rd, rs);
      check({st[0], rd[1:0]}, 3'b000);
      report_and_stop();
   end
endmodule
